// ---- rtl/sreu_defs.svh ----
// Offsets, reset values, opcodes and cycle counts for the stack/rotate unit
`ifndef SREU_DEFS_SVH
`define SREU_DEFS_SVH

// Register byte offsets, decoded on haddr[7:0]
`define SREU_OFS_INSTR 8'h00
`define SREU_OFS_CMD 8'h04
`define SREU_OFS_STATUS 8'h08
`define SREU_OFS_FLAGS 8'h0c
`define SREU_OFS_SP 8'h10
`define SREU_OFS_PC 8'h14
`define SREU_OFS_MADDR 8'h18
`define SREU_OFS_MDATA 8'h1c

// Field positions
`define SREU_CMD_GO_BIT 0
`define SREU_ST_BUSY_BIT 0
`define SREU_ST_DONE_BIT 1
`define SREU_ST_BAD_BIT 2

// Reset values
`define SREU_FLAGS_RST 8'h00
`define SREU_SP_RST 16'h0000
`define SREU_PC_RST 16'h0000
`define SREU_INSTR_RST 24'h000000

// Opcodes
`define SREU_OPC_PUSH_DN 8'h82
`define SREU_OPC_PUSH_UP 8'h83
`define SREU_OPC_CLR_C 8'hcf
`define SREU_OPC_RET 8'haf
`define SREU_OPC_ROT_L 8'h90
`define SREU_OPC_ROT_L_I 8'h91
`define SREU_OPC_ROT_LC 8'h10
`define SREU_OPC_ROT_LC_I 8'h11
`define SREU_OPC_ROT_R 8'he0
`define SREU_OPC_ROT_R_I 8'he1
`define SREU_OPC_ROT_RC 8'hc0
`define SREU_OPC_ROT_RC_I 8'hc1

// Execution lengths in CPU cycles
`define SREU_CYC_PUSH 4'd8
`define SREU_CYC_CLR_C 4'd4
`define SREU_CYC_RET_INT 4'd8
`define SREU_CYC_RET_EXT 4'd10
`define SREU_CYC_ROT 4'd4

// Return pops two bytes
`define SREU_RET_STEP 16'h0002

`endif

// ---- rtl/sreu_pkg.sv ----
// Types shared by the stack/rotate execution unit
package sreu_pkg;

    // Flag byte, most significant bit first
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
        logic [1:0] spare;
    } sreu_flags_t;

    // Instruction word held for execution
    typedef struct packed {
        logic [7:0] src;
        logic [7:0] dst;
        logic [7:0] opc;
    } sreu_instr_t;

    typedef enum logic [2:0] {
        SREU_OP_NONE,
        SREU_OP_PUSH_DN,
        SREU_OP_PUSH_UP,
        SREU_OP_CLR_C,
        SREU_OP_RET,
        SREU_OP_ROT
    } sreu_op_t;

    typedef enum logic [1:0] {
        SREU_ROT_L,
        SREU_ROT_LC,
        SREU_ROT_R,
        SREU_ROT_RC
    } sreu_rot_t;

    // Rotate result and its flag effects
    typedef struct packed {
        logic [7:0] value;
        logic c;
        logic z;
        logic s;
        logic v;
    } sreu_rot_res_t;

endpackage

// ---- rtl/sreu_rotate.sv ----
// One-bit rotate datapath with carry, zero, sign and overflow results
`timescale 1ns/1ps
module sreu_rotate
    import sreu_pkg::*;
(
    input wire logic [7:0] value_i,
    input wire logic carry_i,
    input sreu_rot_t mode_i,
    output sreu_rot_res_t res_o
);

    logic [7:0] rot_val;
    logic rot_c;

    // Bit movement per mode
    always_comb begin
        rot_val = value_i;
        rot_c = carry_i;
        case (mode_i)
            // RL8 old bit 7 into bit 0 and carry
            SREU_ROT_L: begin
                rot_val = {value_i[6:0], value_i[7]};
                rot_c = value_i[7];
            end
            // RL9 old carry into bit 0
            SREU_ROT_LC: begin
                rot_val = {value_i[6:0], carry_i};
                rot_c = value_i[7];
            end
            // RL10 old bit 0 into bit 7 and carry
            SREU_ROT_R: begin
                rot_val = {value_i[0], value_i[7:1]};
                rot_c = value_i[0];
            end
            // RL11 old carry into bit 7
            SREU_ROT_RC: begin
                rot_val = {carry_i, value_i[7:1]};
                rot_c = value_i[0];
            end
            default: begin
                rot_val = value_i;
                rot_c = carry_i;
            end
        endcase
    end

    // Flag effects of all rotates
    always_comb begin
        res_o.value = rot_val;
        // RL13 carry is the bit that left
        res_o.c = rot_c;
        // RL14 zero and sign from result
        res_o.z = (rot_val == 8'h00);
        res_o.s = rot_val[7];
        // RL15 sign change means overflow
        res_o.v = rot_val[7] ^ value_i[7];
    end

endmodule // sreu_rotate

// ---- rtl/sreu_top.sv ----
// Stack, carry-clear, return and rotate execution unit with AHB-Lite registers
// Function
// RL1: Push-down (82h, 3 bytes, 8 cycles) lowers the user pointer, stores src there, flags kept.
// RL2: Push-up (83h, 3 bytes, 8 cycles) raises the user pointer, stores src there, flags kept.
// RL3: For both pushes dst is a register holding the user pointer and src is a direct register.
// RL4: Clear-carry (CFh, 1 byte, 4 cycles) forces carry to zero and leaves other flags alone.
// RL5: Return (AFh) loads the program counter from the stack at the pointer and adds two to it.
// RL6: Return takes 8 cycles with an internal stack and 10 with an external one.
// RL7: Return takes the byte at the pointer as the high byte and the next byte as the low byte.
// RL8: Rotate left (90h direct, 91h indirect, 4 cycles) copies old bit 7 into bit 0 and carry.
// RL9: Rotate left through carry (10h/11h, 4 cycles) moves bit 7 to carry and carry to bit 0.
// RL10: Rotate right (E0h/E1h, 4 cycles) copies old bit 0 into bit 7 and carry.
// RL11: Rotate right through carry moves bit 0 to carry and the old carry to bit 7.
// RL12: Rotate right through carry uses C0h direct and C1h indirect, 2 bytes and 4 cycles.
// RL13: Every rotate sets carry from the bit that leaves the operand.
// RL14: Every rotate sets zero on a zero result and sign from result bit 7; D and H stay.
// RL15: Every rotate sets overflow when bit 7 differs before and after.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "sreu_defs.svh"
module sreu_top
    import sreu_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter bit EXT_STACK = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o
);

    localparam int AW = $clog2(DEPTH);

    // Byte array must be indexable by 8-bit register numbers
    if (DEPTH < 2 || DEPTH > 256 || (1 << AW) != DEPTH) begin : g_depth_chk
        $error("sreu_top: DEPTH must be a power of two from 2 to 256");
    end

    // Bus data phase state
    logic dp_rd;
    logic dp_wr;
    logic rd_ready;
    logic [7:0] dp_addr;
    logic acc;
    logic wr_en;

    // Architectural state
    logic [7:0] mem [DEPTH];
    sreu_flags_t flags;
    logic [15:0] stack_ptr;
    logic [15:0] program_counter;
    logic [7:0] maddr;
    sreu_instr_t instr;

    // Execution control
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN
    } sreu_state_t;
    sreu_state_t state;
    logic [3:0] cnt;
    logic [7:0] work_ptr;
    logic done;
    logic bad;
    logic go;
    logic fin;
    sreu_op_t op;
    sreu_rot_t rot_mode;
    logic rot_ind;
    logic [3:0] op_cycles;
    logic [AW-1:0] rot_addr;
    logic [7:0] push_ptr;
    sreu_rot_res_t rot_res;
    logic [31:0] rd_mux;

    // Address phase taken only when the previous transfer has finished
    assign acc = hsel_i & htrans_i[1] & hready_i;
    assign wr_en = dp_wr;
    // Reads insert one wait so a write just before is already visible
    assign hreadyout_o = ~(dp_rd & ~rd_ready);
    assign hresp_o = 1'b0;

    // Data phase tracking
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dp_rd <= 1'b0;
            dp_wr <= 1'b0;
            rd_ready <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hreadyout_o) begin
            dp_rd <= acc & ~hwrite_i;
            dp_wr <= acc & hwrite_i;
            rd_ready <= 1'b0;
            if (acc) begin
                dp_addr <= haddr_i[7:0];
            end
        end else begin
            rd_ready <= 1'b1;
        end
    end

    // Read data mux; unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (dp_addr)
            `SREU_OFS_INSTR: rd_mux = {8'h00, instr};
            `SREU_OFS_STATUS: begin
                rd_mux[`SREU_ST_BUSY_BIT] = (state == ST_RUN);
                rd_mux[`SREU_ST_DONE_BIT] = done;
                rd_mux[`SREU_ST_BAD_BIT] = bad;
            end
            `SREU_OFS_FLAGS: rd_mux = {24'h000000, flags};
            `SREU_OFS_SP: rd_mux = {16'h0000, stack_ptr};
            `SREU_OFS_PC: rd_mux = {16'h0000, program_counter};
            `SREU_OFS_MADDR: rd_mux = {24'h000000, maddr};
            `SREU_OFS_MDATA: rd_mux = {24'h000000, mem[maddr[AW-1:0]]};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Read data registered in the wait cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_o <= 32'h00000000;
        end else if (dp_rd & ~rd_ready) begin
            hrdata_o <= rd_mux;
        end
    end

    // Opcode decode
    always_comb begin
        op = SREU_OP_NONE;
        rot_mode = SREU_ROT_L;
        rot_ind = instr.opc[0];
        op_cycles = `SREU_CYC_ROT;
        case (instr.opc)
            // RL1 push-down, 8 cycles
            `SREU_OPC_PUSH_DN: begin
                op = SREU_OP_PUSH_DN;
                op_cycles = `SREU_CYC_PUSH;
            end
            // RL2 push-up, 8 cycles
            `SREU_OPC_PUSH_UP: begin
                op = SREU_OP_PUSH_UP;
                op_cycles = `SREU_CYC_PUSH;
            end
            // RL4 clear carry, 4 cycles
            `SREU_OPC_CLR_C: begin
                op = SREU_OP_CLR_C;
                op_cycles = `SREU_CYC_CLR_C;
            end
            // RL6 return length by stack place
            `SREU_OPC_RET: begin
                op = SREU_OP_RET;
                op_cycles = EXT_STACK ? `SREU_CYC_RET_EXT : `SREU_CYC_RET_INT;
            end
            // RL8 rotate left opcodes
            `SREU_OPC_ROT_L, `SREU_OPC_ROT_L_I: begin
                op = SREU_OP_ROT;
                rot_mode = SREU_ROT_L;
            end
            // RL9 rotate left through carry opcodes
            `SREU_OPC_ROT_LC, `SREU_OPC_ROT_LC_I: begin
                op = SREU_OP_ROT;
                rot_mode = SREU_ROT_LC;
            end
            // RL10 rotate right opcodes
            `SREU_OPC_ROT_R, `SREU_OPC_ROT_R_I: begin
                op = SREU_OP_ROT;
                rot_mode = SREU_ROT_R;
            end
            // RL12 rotate right through carry opcodes
            `SREU_OPC_ROT_RC, `SREU_OPC_ROT_RC_I: begin
                op = SREU_OP_ROT;
                rot_mode = SREU_ROT_RC;
            end
            default: begin
                op = SREU_OP_NONE;
            end
        endcase
    end

    // Start request from a command write while idle
    assign go = wr_en & (dp_addr == `SREU_OFS_CMD) & hwdata_i[`SREU_CMD_GO_BIT]
        & (state == ST_IDLE);
    // Last cycle of an instruction, where its result lands
    assign fin = (state == ST_RUN) & (cnt == 4'd1);

    // RL3 dst names the register holding the user pointer
    always_comb begin
        if (op == SREU_OP_PUSH_DN) begin
            push_ptr = mem[instr.dst[AW-1:0]] - 8'h01;
        end else begin
            push_ptr = mem[instr.dst[AW-1:0]] + 8'h01;
        end
    end

    // Rotate target: direct register or the register it points to
    assign rot_addr = rot_ind ? mem[instr.dst[AW-1:0]][AW-1:0] : instr.dst[AW-1:0];

    sreu_rotate u_rotate (
        .value_i(mem[rot_addr]),
        .carry_i(flags.c),
        .mode_i(rot_mode),
        .res_o(rot_res)
    );

    // Sequencer and cycle counter
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            cnt <= 4'd0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go && op != SREU_OP_NONE) begin
                        state <= ST_RUN;
                        cnt <= op_cycles - 4'd1;
                    end
                end
                ST_RUN: begin
                    cnt <= cnt - 4'd1;
                    if (cnt == 4'd1) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Done and bad-opcode status; a new completion beats a clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done <= 1'b0;
            bad <= 1'b0;
        end else begin
            if (fin || (go && op == SREU_OP_NONE)) begin
                done <= 1'b1;
            end else if (wr_en && dp_addr == `SREU_OFS_STATUS
                         && hwdata_i[`SREU_ST_DONE_BIT]) begin
                done <= 1'b0;
            end
            if (go) begin
                bad <= (op == SREU_OP_NONE);
            end
        end
    end

    // Instruction word, frozen while running
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            instr <= `SREU_INSTR_RST;
        end else if (wr_en && dp_addr == `SREU_OFS_INSTR && state == ST_IDLE) begin
            instr <= hwdata_i[23:0];
        end
    end

    // Pointer captured at start for the later store
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            work_ptr <= 8'h00;
        end else if (go) begin
            work_ptr <= push_ptr;
        end
    end

    // Register file: pointer update first, source store last
    always_ff @(posedge clk_sys_i) begin
        if (go && (op == SREU_OP_PUSH_DN || op == SREU_OP_PUSH_UP)) begin
            // RL1 RL2 pointer moves first
            mem[instr.dst[AW-1:0]] <= push_ptr;
        end else if (fin && (op == SREU_OP_PUSH_DN || op == SREU_OP_PUSH_UP)) begin
            // RL1 RL2 store at moved pointer
            mem[work_ptr[AW-1:0]] <= mem[instr.src[AW-1:0]];
        end else if (fin && op == SREU_OP_ROT) begin
            // RL8 rotated value back to target
            mem[rot_addr] <= rot_res.value;
        end else if (wr_en && dp_addr == `SREU_OFS_MDATA && state == ST_IDLE) begin
            mem[maddr[AW-1:0]] <= hwdata_i[7:0];
        end
    end

    // Window address for software access to the register file
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            maddr <= 8'h00;
        end else if (wr_en && dp_addr == `SREU_OFS_MADDR) begin
            maddr <= hwdata_i[7:0];
        end
    end

    // Flags; pushes and return leave them untouched
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags <= `SREU_FLAGS_RST;
        end else if (fin && op == SREU_OP_CLR_C) begin
            // RL4 only carry cleared
            flags.c <= 1'b0;
        end else if (fin && op == SREU_OP_ROT) begin
            // RL13 RL14 RL15 rotate flags, D and H kept
            flags.c <= rot_res.c;
            flags.z <= rot_res.z;
            flags.s <= rot_res.s;
            flags.v <= rot_res.v;
        end else if (wr_en && dp_addr == `SREU_OFS_FLAGS && state == ST_IDLE) begin
            flags <= hwdata_i[7:0];
        end
    end

    // System stack pointer
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stack_ptr <= `SREU_SP_RST;
        end else if (fin && op == SREU_OP_RET) begin
            // RL5 pop two bytes
            stack_ptr <= stack_ptr + `SREU_RET_STEP;
        end else if (wr_en && dp_addr == `SREU_OFS_SP && state == ST_IDLE) begin
            stack_ptr <= hwdata_i[15:0];
        end
    end

    // Program counter; fetch resumes from the popped value
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            program_counter <= `SREU_PC_RST;
        end else if (fin && op == SREU_OP_RET) begin
            // RL5 RL7 high byte first, then low
            program_counter <= {mem[stack_ptr[AW-1:0]], mem[AW'(stack_ptr + 16'h0001)]};
        end else if (wr_en && dp_addr == `SREU_OFS_PC && state == ST_IDLE) begin
            program_counter <= hwdata_i[15:0];
        end
    end

endmodule // sreu_top

// ---- tb/sreu_asserts.sv ----
// Bus timing and completion checks for the stack/rotate unit
`timescale 1ns/1ps
module sreu_asserts (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] hrdata_o
);
    logic take;
    logic cmd_ph;
    logic [7:0] since_go;

    // Transfer accepted at this edge
    assign take = hsel_i & htrans_i[1] & hready_i;

    // Cycles since the last start; saturates so it never wraps back to busy
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_ph <= 1'b0;
            since_go <= 8'hff;
        end else begin
            cmd_ph <= take & hwrite_i & (haddr_i[7:0] == 8'h04);
            if (cmd_ph & hwdata_i[0])
                since_go <= 8'h00;
            else if (since_go != 8'hff)
                since_go <= since_go + 8'h01;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    okay_resp_a: assert property (hresp_o == 1'b0)
        else $error("response not OKAY");
    write_nowait_a: assert property (take && hwrite_i |=> hreadyout_o)
        else $error("write data phase stalled");
    read_wait_a: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    wait_cause_a: assert property (!hreadyout_o |-> $past(take && !hwrite_i))
        else $error("stall without a read");
    rdata_hold_a: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
        else $error("read data changed outside a read");
    cmd_zero_a: assert property (take && !hwrite_i && haddr_i[7:0] == 8'h04
        |-> ##2 hrdata_o == 32'h00000000) else $error("command register read not zero");
    unmapped_zero_a: assert property (take && !hwrite_i && haddr_i[7:0] >= 8'h20
        |-> ##2 hrdata_o == 32'h00000000) else $error("unmapped read not zero");
    flags_width_a: assert property (take && !hwrite_i && haddr_i[7:0] == 8'h0c
        |-> ##2 hrdata_o[31:8] == 24'h000000) else $error("flag byte upper bits set");
    busy_bound_a: assert property (
        take && !hwrite_i && haddr_i[7:0] == 8'h08 && since_go >= 8'd9
        |-> ##2 !hrdata_o[0]) else $error("instruction ran too long");
endmodule // sreu_asserts

// ---- tb/sreu_ahb_master.sv ----
// Single-transfer bus master standing in for the host side
`timescale 1ns/1ps
module sreu_ahb_master (
    input wire logic clk_sys_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    // Idle bus from time zero; word size only
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h00000000;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'b010;
        hwdata_o = 32'h00000000;
    end

    // One word; gap idles first so the host can be prompt or slow
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                        input int gap, output logic [31:0] rd);
        repeat (gap) @(posedge clk_sys_i);
        hsel_o <= 1'b1;
        haddr_o <= {24'h000000, ofs};
        htrans_o <= 2'b10;
        hwrite_o <= wr;
        @(posedge clk_sys_i);
        while (hready_i !== 1'b1) @(posedge clk_sys_i);
        hsel_o <= 1'b0;
        htrans_o <= 2'b00;
        haddr_o <= ~haddr_o;
        hwdata_o <= wr ? wd : ~hwdata_o;
        @(posedge clk_sys_i);
        while (hready_i !== 1'b1) @(posedge clk_sys_i);
        rd = hrdata_i;
        // Released data line must not keep its last value
        hwdata_o <= ~wd;
    endtask
endmodule // sreu_ahb_master

// ---- tb/sreu_tb_top.sv ----
// Self-checking bench for the stack/rotate unit through its register bus
`timescale 1ns/1ps
module sreu_tb_top;
    logic clk_sys, reset_n, hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int errors;
    int comparisons;

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    sreu_top #(.DEPTH(256), .EXT_STACK(1'b0)) dut_u (.clk_sys_i(clk_sys),
        .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata));

    sreu_ahb_master host_u (.clk_sys_i(clk_sys), .hready_i(hready), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] x;
        host_u.xfer(1'b1, ofs, d, 0, x);
    endtask

    task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] d;
        host_u.xfer(1'b0, ofs, 32'h0, 0, d);
        chk(d, exp);
    endtask

    task automatic mset(input logic [7:0] a, input logic [7:0] v);
        wr(8'h18, {24'h0, a});
        wr(8'h1c, {24'h0, v});
    endtask

    task automatic mchk(input logic [7:0] a, input logic [7:0] v);
        wr(8'h18, {24'h0, a});
        rdc(8'h1c, {24'h0, v});
    endtask

    // Start, then poll status one cycle before or exactly at completion
    task automatic run(input logic [23:0] ins, input int n, input bit early);
        logic [31:0] d;
        wr(8'h00, {8'h00, ins});
        wr(8'h04, 32'h1);
        host_u.xfer(1'b0, 8'h08, 32'h0, early ? n - 3 : n - 2, d);
        chk(d, early ? 32'h1 : 32'h2);
        wr(8'h08, 32'h2);
        // Idle long after the start, so the busy bound is exercised on the 8-cycle runs only
        rdc(8'h08, 32'h0);
    endtask

    // Reset values, command readback and an unmapped slot
    task automatic t_reset;
        for (int i = 0; i < 7; i++)
            rdc(8'(i * 4), 32'h0);
        wr(8'h40, 32'hffffffff);
        rdc(8'h40, 32'h0);
    endtask

    task automatic t_push_dn;
        wr(8'h0c, 32'hb4);
        mset(8'h00, 8'h00);
        mset(8'h01, 8'h05);
        run(24'h010082, 8, 1'b0);
        mchk(8'h00, 8'hff);
        mchk(8'hff, 8'h05);
        mchk(8'h01, 8'h05);
        rdc(8'h0c, 32'hb4);
    endtask

    task automatic t_push_up;
        mset(8'h00, 8'h03);
        mset(8'h03, 8'h77);
        run(24'h010083, 8, 1'b1);
        mchk(8'h00, 8'h04);
        mchk(8'h04, 8'h05);
        mchk(8'h03, 8'h77);
        rdc(8'h0c, 32'hb4);
    endtask

    // carry clear from set and from clear
    task automatic t_clr_c;
        wr(8'h0c, 32'hff);
        run(24'h0000cf, 4, 1'b0);
        rdc(8'h0c, 32'h7f);
        wr(8'h0c, 32'h3c);
        run(24'h0000cf, 4, 1'b1);
        rdc(8'h0c, 32'h3c);
    endtask

    task automatic t_ret;
        wr(8'h10, 32'h00fc);
        wr(8'h14, 32'h1234);
        mset(8'hfc, 8'h10);
        mset(8'hfd, 8'h1a);
        run(24'h0000af, 8, 1'b1);
        rdc(8'h14, 32'h101a);
        rdc(8'h10, 32'h00fe);
        rdc(8'h0c, 32'h3c);
    endtask

    // every rotate code, direct and indirect
    task automatic t_rotate;
        logic [7:0] opc [9] = '{8'h90, 8'h91, 8'h10, 8'h11, 8'he0, 8'he1, 8'hc0, 8'hc1, 8'h10};
        logic [7:0] val [9] = '{8'haa, 8'h17, 8'haa, 8'h17, 8'h31, 8'h17, 8'h55, 8'h17, 8'h80};
        logic [7:0] v, r;
        logic ci, co;
        for (int i = 0; i < 9; i++) begin
            v = val[i];
            ci = i[1];
            wr(8'h0c, {24'h0, ci, 7'h5c});
            if (opc[i][0])
                mset(8'h02, v);
            mset(8'h01, opc[i][0] ? 8'h02 : v);
            case (opc[i][7:4])
                4'h9: r = {v[6:0], v[7]};
                4'h1: r = {v[6:0], ci};
                4'he: r = {v[0], v[7:1]};
                default: r = {ci, v[7:1]};
            endcase
            co = opc[i][6] ? v[0] : v[7];
            run({16'h0001, opc[i]}, 4, i[0]);
            mchk(opc[i][0] ? 8'h02 : 8'h01, r);
            rdc(8'h0c, {24'h0, co, r == 8'h00, r[7], r[7] ^ v[7], 4'hc});
        end
    endtask

    // Unknown opcode finishes at once with the bad flag
    task automatic t_bad;
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h1);
        rdc(8'h08, 32'h6);
        wr(8'h08, 32'h2);
    endtask

    task automatic test_done;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence; reset released on an edge
    initial begin
        errors = 0;
        comparisons = 0;
        reset_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset;
        t_push_dn;
        t_push_up;
        t_clr_c;
        t_ret;
        t_rotate;
        t_bad;
        test_done;
    end

    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        test_done;
    end
endmodule // sreu_tb_top

bind sreu_top sreu_asserts chk_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o));
